// ==== isolated_switch_enable_control.sv ====
`timescale 1ns/1ps
// Contract
// R1 - two-wire enable current bounded by selected level
// R2 - seven codes map 1.9 to 6.7 mA
// R3 - level latched at power-up, held until repower
// R4 - two-wire burst waits for primary upper threshold
// R5 - each two-wire burst lasts 3.3 us
// R6 - bursts repeat hysteretically until high rail charged
// R7 - two-wire gate high after rail charged, follows enable
// R8 - enable fall sends deassert, gate goes low
// R9 - controller raises enable to start, lowers to stop
// R10 - gate low while either supply locked out
// R11 - gate high only with both supplies up
// R12 - lockout uses separate rising and falling thresholds
// R13 - secondary monitor ignores brief switching droop
// R14 - thermal trip stops transfer, forces gate low
// R15 - transfer stays off until temperature clears
// R16 - standard variant gate equals enable
// R17 - one-shot variant pulses gate on enable rise
// R18 - one-shot rearms only after enable seen low
// R19 - secondary times out gate without primary commands
// R20 - three-wire transfers continuously, duty by level
// R21 - thresholds arrive as synchronous status inputs
// R22 - one-shot width is a parameter
module isolated_switch_enable_control #(
  parameter int ONESHOT_NS   = 1000,
  parameter int WATCHDOG_NS  = 2000,
  parameter int PERIOD_3W_NS = 3750,
  parameter int DROOP_NS     = 500
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        enableIn,
  input  wire logic        threeWireMode,
  input  wire logic        oneShotVariant,
  input  wire logic [2:0]  levelSelectCode,
  input  wire logic        primaryAboveRise,
  input  wire logic        primaryBelowFall,
  input  wire logic        primaryUpperReached,
  input  wire logic        highRailAboveRise,
  input  wire logic        highRailBelowFall,
  input  wire logic        highRailCharged,
  input  wire logic        overTemp,
  output logic             gateDriveOut,
  output logic             powerTransferOn,
  output logic             deassertCmd,
  output logic [2:0]       powerLevel,
  output logic [12:0]      enableLimitMicroamp,
  output logic             levelLatched,
  output logic             primaryPowered,
  output logic             secondaryPowered,
  output logic             thermalShutdown,
  output logic             keepOffActive
);

  localparam int CLK_NS = switch_ctrl_pkg::CLOCK_PERIOD_NS;
  localparam int TW     = switch_ctrl_pkg::TIMER_W;

  // longest times round down, least times round up, never below one cycle
  localparam int ONESHOT_RAW  = ONESHOT_NS / CLK_NS;
  localparam int ONESHOT_CYC  = (ONESHOT_RAW < 1) ? 1 : ONESHOT_RAW;
  localparam int WATCHDOG_RAW = (WATCHDOG_NS + CLK_NS - 1) / CLK_NS;
  localparam int WATCHDOG_CYC = (WATCHDOG_RAW < 1) ? 1 : WATCHDOG_RAW;
  localparam int PERIOD_RAW   = PERIOD_3W_NS / CLK_NS;
  localparam int PERIOD_CYC   = (PERIOD_RAW < 1) ? 1 : PERIOD_RAW;
  localparam int DROOP_RAW    = DROOP_NS / CLK_NS;
  localparam int DROOP_CYC    = (DROOP_RAW < 1) ? 1 : DROOP_RAW;
  localparam int STEP_CYC     = PERIOD_CYC * switch_ctrl_pkg::DUTY_PER_LEVEL
                                / switch_ctrl_pkg::DUTY_STEPS;

  typedef struct packed {
    switch_ctrl_pkg::two_wire_e twState;
    logic                       enablePrev;
    logic                       oneShotArmed;
    logic                       levelValid;
    logic [2:0]                 level;
    logic [12:0]                limitUa;
    logic [TW-1:0]              periodCount;
    logic [TW-1:0]              watchdogCount;
    logic                       keepOff;
    logic                       thermal;
    logic                       gate;
    logic                       transfer;
    logic                       deassert;
    logic                       railReady;
  } ctrl_s;

  ctrl_s state_q;
  ctrl_s state_d;

  logic primaryOk;
  logic highOk;
  logic burstBusy;
  logic burstDone;
  logic oneShotBusy;
  logic burstStart;
  logic oneShotStart;
  logic enableRise;
  logic enableFall;
  logic twActive;

  // primary monitor, hysteresis only
  supply_monitor #(
    .DROOP_CYCLES (1)
  ) primaryMon (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .aboveRise (primaryAboveRise),   // see R12
    .belowFall (primaryBelowFall),
    .poweredUp (primaryOk)
  );

  // secondary monitor filters switching droop
  supply_monitor #(
    .DROOP_CYCLES (DROOP_CYC)
  ) highRailMon (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .aboveRise (highRailAboveRise),  // see R12
    .belowFall (highRailBelowFall),  // see R13
    .poweredUp (highOk)
  );

  // fixed two-wire burst on-time
  pulse_timer #(
    .WIDTH (TW)
  ) burstTimer (
    .clock   (clock),
    .sys_rst (sys_rst),
    .start   (burstStart),
    .length  (TW'(switch_ctrl_pkg::BURST_ON_CYCLES)),  // see R5
    .busy    (burstBusy),
    .done    (burstDone)
  );

  // one-shot gate pulse width
  pulse_timer #(
    .WIDTH (TW)
  ) oneShotTimer (
    .clock   (clock),
    .sys_rst (sys_rst),
    .start   (oneShotStart),
    .length  (TW'(ONESHOT_CYC)),  // see R22
    .busy    (oneShotBusy),
    .done    ()
  );

  // enable edges on the internal clock
  assign enableRise = enableIn && !state_q.enablePrev;  // see R21
  assign enableFall = !enableIn && state_q.enablePrev;
  assign twActive   = !threeWireMode;

  // two-wire burst launch once primary reaches upper threshold
  assign burstStart = twActive && (state_q.twState == switch_ctrl_pkg::TW_CHARGE)
                      && primaryUpperReached && enableIn && !state_q.thermal;  // see R4

  // one-shot only in three-wire, rearmed by a low enable
  assign oneShotStart = threeWireMode && oneShotVariant && enableRise
                        && state_q.oneShotArmed;  // see R17, R18

  always_comb begin
    logic          suppliesUp;
    logic          gateWant;
    logic [TW-1:0] onCycles;
    suppliesUp = 1'b0;
    gateWant   = 1'b0;
    onCycles   = '0;
    state_d    = state_q;

    state_d.enablePrev = enableIn;

    // thermal indication held off until it clears
    state_d.thermal = overTemp;  // see R14, R15

    // level sampled once per primary power cycle
    if (!primaryOk) begin
      state_d.levelValid = 1'b0;  // see R3
    end else if (!state_q.levelValid) begin
      state_d.levelValid = 1'b1;
      if (levelSelectCode > switch_ctrl_pkg::LEVEL_MAX_CODE) begin
        state_d.level = switch_ctrl_pkg::LEVEL_DEFAULT;  // see R2
      end else begin
        state_d.level = levelSelectCode;  // see R3
      end
    end
    state_d.limitUa = switch_ctrl_pkg::ENABLE_LIMIT_UA[state_d.level];  // see R1, R2

    // one-shot rearm tracking
    if (!enableIn) begin
      state_d.oneShotArmed = 1'b1;  // see R18
    end else if (oneShotStart) begin
      state_d.oneShotArmed = 1'b0;
    end

    // two-wire sequencing, controller supplies power through enable
    case (state_q.twState)
      switch_ctrl_pkg::TW_OFF: begin
        if (twActive && enableIn && !state_q.thermal) begin
          state_d.twState = switch_ctrl_pkg::TW_CHARGE;  // see R9
        end
      end
      switch_ctrl_pkg::TW_CHARGE: begin
        if (!twActive || !enableIn || state_q.thermal) begin
          state_d.twState = switch_ctrl_pkg::TW_OFF;
        end else if (burstStart) begin
          state_d.twState = switch_ctrl_pkg::TW_BURST;
        end
      end
      switch_ctrl_pkg::TW_BURST: begin
        if (!twActive || !enableIn || state_q.thermal) begin
          state_d.twState = switch_ctrl_pkg::TW_OFF;
        end else if (burstDone) begin
          if (highRailCharged && highOk) begin
            state_d.twState = switch_ctrl_pkg::TW_RUN;  // see R6, R7
          end else begin
            state_d.twState = switch_ctrl_pkg::TW_CHARGE;  // see R6
          end
        end
      end
      switch_ctrl_pkg::TW_RUN: begin
        if (!twActive || !enableIn || state_q.thermal) begin
          state_d.twState = switch_ctrl_pkg::TW_OFF;  // see R8
        end else if (!highRailCharged) begin
          state_d.twState = switch_ctrl_pkg::TW_CHARGE;  // see R6
        end
      end
      default: begin
        state_d.twState = switch_ctrl_pkg::TW_OFF;
      end
    endcase

    // rail-ready latch keeps gate through recharge bursts
    if (state_d.twState == switch_ctrl_pkg::TW_RUN) begin
      state_d.railReady = 1'b1;  // see R7
    end else if (state_d.twState == switch_ctrl_pkg::TW_OFF) begin
      state_d.railReady = 1'b0;
    end

    // three-wire fixed period, on-time from latched level
    onCycles = TW'(STEP_CYC * (int'(state_q.level) + 1));
    if (threeWireMode && primaryOk && !state_q.thermal) begin
      if (state_q.periodCount >= TW'(PERIOD_CYC - 1)) begin
        state_d.periodCount = '0;
      end else begin
        state_d.periodCount = state_q.periodCount + TW'(1);  // see R20
      end
    end else begin
      state_d.periodCount = '0;
    end

    // transfer indication
    if (state_q.thermal) begin
      state_d.transfer = 1'b0;  // see R14
    end else if (threeWireMode) begin
      state_d.transfer = primaryOk && (state_q.periodCount < onCycles);  // see R20
    end else begin
      state_d.transfer = burstBusy && enableIn;  // see R5, R6
    end

    // secondary watchdog: no primary commands arrive without primary power
    if (primaryOk) begin
      state_d.watchdogCount = '0;
      state_d.keepOff       = 1'b0;
    end else if (highOk && !state_q.keepOff) begin
      if (state_q.watchdogCount >= TW'(WATCHDOG_CYC - 1)) begin
        state_d.keepOff = 1'b1;  // see R19
      end else begin
        state_d.watchdogCount = state_q.watchdogCount + TW'(1);
      end
    end

    // gate decision
    suppliesUp = primaryOk && highOk && !state_q.thermal && !state_q.keepOff;  // see R10, R11
    if (!threeWireMode) begin
      gateWant = enableIn && state_q.railReady;  // see R7, R16
    end else if (oneShotVariant) begin
      gateWant = oneShotBusy;  // see R17
    end else begin
      gateWant = enableIn;  // see R16
    end
    state_d.gate = suppliesUp && gateWant;  // see R10, R11, R14

    // two-wire only: deassert command on enable fall while gate was driven
    state_d.deassert = twActive && enableFall && state_q.gate;  // see R8
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q              <= '0;
      state_q.twState      <= switch_ctrl_pkg::TW_OFF;
      state_q.level        <= switch_ctrl_pkg::LEVEL_DEFAULT;
      state_q.limitUa      <= switch_ctrl_pkg::LIMIT_UA_RESET;
      state_q.oneShotArmed <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign gateDriveOut        = state_q.gate;
  assign powerTransferOn     = state_q.transfer;
  assign deassertCmd         = state_q.deassert;
  assign powerLevel          = state_q.level;
  assign enableLimitMicroamp = state_q.limitUa;
  assign levelLatched        = state_q.levelValid;
  assign primaryPowered      = primaryOk;
  assign secondaryPowered    = highOk;
  assign thermalShutdown     = state_q.thermal;
  assign keepOffActive       = state_q.keepOff;

endmodule

// ==== switch_ctrl_pkg.sv ====
package switch_ctrl_pkg;

  // system clock
  localparam int CLOCK_PERIOD_NS = 5;

  // two-wire burst on-time, least time so rounded up
  localparam int BURST_ON_NS     = 3300;
  localparam int BURST_ON_CYCLES = (BURST_ON_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // shared timer width
  localparam int TIMER_W = 16;

  // power level coding
  localparam int              LEVEL_W        = 3;
  localparam int              LEVEL_COUNT    = 7;
  localparam logic [2:0]      LEVEL_DEFAULT  = 3'h0;
  localparam logic [2:0]      LEVEL_MAX_CODE = 3'h6;

  // three-wire duty: level n gives 2*(n+1)/15 of the period
  localparam int DUTY_STEPS     = 15;
  localparam int DUTY_PER_LEVEL = 2;

  // enable input current limit per level, microamps
  localparam int LIMIT_UA_W = 13;
  localparam logic [6:0][12:0] ENABLE_LIMIT_UA = {
    13'h1a2c, 13'h1770, 13'h1450, 13'h1194, 13'h0e74, 13'h0af0, 13'h076c
  };
  localparam logic [12:0] LIMIT_UA_RESET = 13'h076c;

  // two-wire sequencing states
  typedef enum logic [3:0] {
    TW_OFF    = 4'b0001,
    TW_CHARGE = 4'b0010,
    TW_BURST  = 4'b0100,
    TW_RUN    = 4'b1000
  } two_wire_e;

endpackage

// ==== pulse_timer.sv ====
`timescale 1ns/1ps
module pulse_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] length,
  output logic                  busy,
  output logic                  done
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             busy;
    logic             done;
  } timer_s;

  timer_s state_q;
  timer_s state_d;

  // counts length cycles from a start while idle
  always_comb begin
    state_d      = state_q;
    state_d.done = 1'b0;
    if (state_q.busy) begin
      if (state_q.count <= WIDTH'(1)) begin
        state_d.busy  = 1'b0;
        state_d.done  = 1'b1;
        state_d.count = '0;
      end else begin
        state_d.count = state_q.count - WIDTH'(1);
      end
    end else if (start) begin
      state_d.busy  = 1'b1;
      state_d.count = length;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign busy = state_q.busy;
  assign done = state_q.done;

endmodule

// ==== supply_monitor.sv ====
`timescale 1ns/1ps
module supply_monitor #(
  parameter int DROOP_CYCLES = 1
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic aboveRise,
  input  wire logic belowFall,
  output logic      poweredUp
);

  typedef struct packed {
    logic [15:0] droopCount;
    logic        powered;
  } monitor_s;

  monitor_s state_q;
  monitor_s state_d;

  // enter on rising threshold, leave on falling threshold held long enough
  always_comb begin
    state_d = state_q;
    if (!state_q.powered) begin
      state_d.droopCount = '0;
      if (aboveRise) begin
        state_d.powered = 1'b1;
      end
    end else if (belowFall) begin
      if (state_q.droopCount >= 16'(DROOP_CYCLES - 1)) begin
        state_d.powered    = 1'b0;
        state_d.droopCount = '0;
      end else begin
        state_d.droopCount = state_q.droopCount + 16'h0001;
      end
    end else begin
      state_d.droopCount = '0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign poweredUp = state_q.powered;

endmodule

// ==== switch_ctrl_assertions.sv ====
`timescale 1ns/1ps
module switch_ctrl_assertions #(
  parameter int ONESHOT_NS   = 1000,
  parameter int PERIOD_3W_NS = 3750,
  parameter int DROOP_NS     = 500
) (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       enableIn,
  input wire logic       threeWireMode,
  input wire logic       oneShotVariant,
  input wire logic       primaryAboveRise,
  input wire logic       primaryBelowFall,
  input wire logic       highRailBelowFall,
  input wire logic       gateDriveOut,
  input wire logic       powerTransferOn,
  input wire logic       deassertCmd,
  input wire logic [2:0] powerLevel,
  input wire logic       levelLatched,
  input wire logic       primaryPowered,
  input wire logic       secondaryPowered,
  input wire logic       thermalShutdown,
  input wire logic       keepOffActive
);
  localparam int ON_STEP = 2 * (PERIOD_3W_NS / 5 / 15);
  typedef struct packed {
    logic [9:0] xfer;
    logic [9:0] gate;
    logic [9:0] droop;
  } count_s;
  count_s cnt_q;
  count_s cnt_d;
  // run lengths of transfer, gate and rail droop
  always_comb begin
    cnt_d       = cnt_q;
    cnt_d.xfer  = powerTransferOn ? cnt_q.xfer + 10'h001 : 10'h000;
    cnt_d.gate  = gateDriveOut ? cnt_q.gate + 10'h001 : 10'h000;
    cnt_d.droop = highRailBelowFall ? cnt_q.droop + 10'h001 : 10'h000;
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_hot;
    thermalShutdown [*2];
  endsequence
  sequence s_std_ready;
    $past(threeWireMode) && !$past(oneShotVariant) && $past(primaryPowered) &&
    $past(secondaryPowered) && !$past(thermalShutdown) && !$past(keepOffActive) &&
    !$past(primaryBelowFall);
  endsequence
  chk_gate_lockout: assert property (gateDriveOut |->
    $past(primaryPowered) && $past(secondaryPowered)) else $error("gate high in lockout");
  chk_std_follow: assert property (s_std_ready |-> gateDriveOut == $past(enableIn))
    else $error("gate does not follow enable");
  chk_thermal_off: assert property (s_hot |->
    !gateDriveOut && !powerTransferOn) else $error("thermal not obeyed");
  chk_burst_two: assert property ($fell(powerTransferOn) && !threeWireMode &&
    !$past(threeWireMode) |-> cnt_q.xfer == 10'(switch_ctrl_pkg::BURST_ON_CYCLES))
    else $error("two-wire burst length wrong");
  chk_burst_three: assert property ($fell(powerTransferOn) && threeWireMode &&
    $past(threeWireMode) && !thermalShutdown && primaryPowered |->
    cnt_q.xfer == 10'(ON_STEP * (int'(powerLevel) + 1))) else $error("duty wrong");
  chk_deassert_pulse: assert property (deassertCmd |-> !gateDriveOut &&
    $past(gateDriveOut) ##1 !deassertCmd) else $error("deassert pulse wrong");
  chk_oneshot_width: assert property ($fell(gateDriveOut) && threeWireMode &&
    oneShotVariant |-> cnt_q.gate == 10'(ONESHOT_NS / 5)) else $error("pulse width wrong");
  chk_level_hold: assert property (levelLatched && $past(levelLatched) |->
    $stable(powerLevel)) else $error("level changed while latched");
  chk_droop_filter: assert property ($fell(secondaryPowered) |->
    cnt_q.droop >= 10'(DROOP_NS / 5)) else $error("rail dropped on short droop");
  chk_primary_rise: assert property (!primaryPowered && primaryAboveRise |=>
    primaryPowered) else $error("primary did not power up");
  chk_primary_fall: assert property (primaryPowered && primaryBelowFall |=>
    !primaryPowered) else $error("primary did not lock out");
endmodule

bind isolated_switch_enable_control switch_ctrl_assertions #(
  .ONESHOT_NS(ONESHOT_NS), .PERIOD_3W_NS(PERIOD_3W_NS), .DROOP_NS(DROOP_NS)
) chk (
  .clock(clock), .sys_rst(sys_rst), .enableIn(enableIn), .threeWireMode(threeWireMode),
  .oneShotVariant(oneShotVariant), .primaryAboveRise(primaryAboveRise),
  .primaryBelowFall(primaryBelowFall), .highRailBelowFall(highRailBelowFall),
  .gateDriveOut(gateDriveOut), .powerTransferOn(powerTransferOn), .deassertCmd(deassertCmd),
  .powerLevel(powerLevel), .levelLatched(levelLatched), .primaryPowered(primaryPowered),
  .secondaryPowered(secondaryPowered), .thermalShutdown(thermalShutdown),
  .keepOffActive(keepOffActive)
);

// ==== app_controller.sv ====
`timescale 1ns/1ps
module app_controller (
  input  wire logic clock,
  output logic      enableIn
);
  initial enableIn = 1'b0;
  // enable changes only at falling edges
  task automatic drive(input logic level);
    @(negedge clock);
    enableIn = level;
  endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic        clock;
  logic        sys_rst;
  logic        enableIn;
  logic        threeWireMode;
  logic        oneShotVariant;
  logic [2:0]  levelSelectCode;
  logic        primaryAboveRise;
  logic        primaryBelowFall;
  logic        primaryUpperReached;
  logic        highRailAboveRise;
  logic        highRailBelowFall;
  logic        highRailCharged;
  logic        overTemp;
  logic        gateDriveOut;
  logic        powerTransferOn;
  logic        deassertCmd;
  logic [2:0]  powerLevel;
  logic [12:0] enableLimitMicroamp;
  logic        levelLatched;
  logic        primaryPowered;
  logic        secondaryPowered;
  logic        thermalShutdown;
  logic        keepOffActive;
  int          num_errors = 0;
  int          comparisons = 0;
  int          n;
  always #2.5 clock = ~clock;
  app_controller ctl (.clock(clock), .enableIn(enableIn));
  isolated_switch_enable_control #(
    .ONESHOT_NS(250), .WATCHDOG_NS(500), .PERIOD_3W_NS(375), .DROOP_NS(100)
  ) dut (
    .clock(clock), .sys_rst(sys_rst), .enableIn(enableIn), .threeWireMode(threeWireMode),
    .oneShotVariant(oneShotVariant), .levelSelectCode(levelSelectCode),
    .primaryAboveRise(primaryAboveRise), .primaryBelowFall(primaryBelowFall),
    .primaryUpperReached(primaryUpperReached), .highRailAboveRise(highRailAboveRise),
    .highRailBelowFall(highRailBelowFall), .highRailCharged(highRailCharged),
    .overTemp(overTemp), .gateDriveOut(gateDriveOut), .powerTransferOn(powerTransferOn),
    .deassertCmd(deassertCmd), .powerLevel(powerLevel),
    .enableLimitMicroamp(enableLimitMicroamp), .levelLatched(levelLatched),
    .primaryPowered(primaryPowered), .secondaryPowered(secondaryPowered),
    .thermalShutdown(thermalShutdown), .keepOffActive(keepOffActive)
  );
  task automatic give_verdict;
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [12:0] got, input logic [12:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask
  // transfer-on cycles over a window
  task automatic count_on(input int k, output int c);
    c = 0;
    repeat (k) begin
      @(negedge clock);
      if (powerTransferOn === 1'b1) c++;
    end
  endtask
  task automatic kick_burst;
    primaryUpperReached = 1'b1;
    cyc(1);
    primaryUpperReached = 1'b0;
    count_on(700, n);
  endtask
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    threeWireMode = 1'b1;
    oneShotVariant = 1'b0;
    levelSelectCode = 3'h3;
    primaryAboveRise = 1'b0;
    primaryBelowFall = 1'b0;
    primaryUpperReached = 1'b0;
    highRailAboveRise = 1'b0;
    highRailBelowFall = 1'b0;
    highRailCharged = 1'b0;
    overTemp = 1'b0;
    repeat (16) @(posedge clock);
    check(enableLimitMicroamp, 13'h076c);
    @(negedge clock);
    sys_rst = 1'b0;
    primaryAboveRise = 1'b1;
    highRailAboveRise = 1'b1;
    cyc(4);
    primaryAboveRise = 1'b0;
    highRailAboveRise = 1'b0;
    check(powerLevel, 13'h0003);
    check(enableLimitMicroamp, 13'h1194);
    levelSelectCode = 3'h6;
    cyc(3);
    check(powerLevel, 13'h0003);
    check(primaryPowered, 13'h0001);
    count_on(75, n);
    check(13'(n), 13'h0028);
    ctl.drive(1'b1);
    cyc(2);
    check(gateDriveOut, 13'h0001);
    overTemp = 1'b1;
    cyc(3);
    check(gateDriveOut, 13'h0000);
    check(thermalShutdown, 13'h0001);
    count_on(75, n);
    check(13'(n), 13'h0000);
    overTemp = 1'b0;
    cyc(3);
    check(gateDriveOut, 13'h0001);
    highRailBelowFall = 1'b1;
    cyc(10);
    check(secondaryPowered, 13'h0001);
    cyc(15);
    check(gateDriveOut, 13'h0000);
    highRailBelowFall = 1'b0;
    highRailAboveRise = 1'b1;
    cyc(2);
    highRailAboveRise = 1'b0;
    check(gateDriveOut, 13'h0001);
    ctl.drive(1'b0);
    cyc(2);
    check(gateDriveOut, 13'h0000);
    oneShotVariant = 1'b1;
    ctl.drive(1'b1);
    cyc(3);
    check(gateDriveOut, 13'h0001);
    cyc(60);
    check(gateDriveOut, 13'h0000);
    ctl.drive(1'b0);
    ctl.drive(1'b1);
    cyc(3);
    check(gateDriveOut, 13'h0001);
    cyc(60);
    ctl.drive(1'b0);
    oneShotVariant = 1'b0;
    primaryBelowFall = 1'b1;
    cyc(2);
    primaryBelowFall = 1'b0;
    check(levelLatched, 13'h0000);
    cyc(110);
    check(keepOffActive, 13'h0001);
    levelSelectCode = 3'h7;
    primaryAboveRise = 1'b1;
    cyc(4);
    primaryAboveRise = 1'b0;
    check(keepOffActive, 13'h0000);
    check(enableLimitMicroamp, 13'h076c);
    count_on(75, n);
    check(13'(n), 13'h000a);
    for (n = 0; n < 100 && powerTransferOn !== 1'b0; n++) @(negedge clock);
    threeWireMode = 1'b0;
    ctl.drive(1'b1);
    cyc(5);
    check(powerTransferOn, 13'h0000);
    kick_burst();
    check(13'(n), 13'h0294);
    check(gateDriveOut, 13'h0000);
    highRailCharged = 1'b1;
    kick_burst();
    check(13'(n), 13'h0294);
    check(gateDriveOut, 13'h0001);
    highRailCharged = 1'b0;
    cyc(3);
    check(gateDriveOut, 13'h0001);
    ctl.drive(1'b0);
    cyc(1);
    check(deassertCmd, 13'h0001);
    check(gateDriveOut, 13'h0000);
    give_verdict();
  end
endmodule
